/* hdl/eipe_ctrl.sv */
// What this block does
// - bit 7 sets timer-3 high priority
// - bit 6 sets comparator-1 high priority
// - bit 5 sets comparator-0 high priority
// - bit 0 sets two-wire bus priority
// - enable bits 7..2 read zero, ignore writes
// - enable bit 1 gates port-match request
// - enable bit 0 reads zero, ignores writes
// - priority bit 1 sets port-match level
`timescale 1ns/1ns
`default_nettype none
module eipe_ctrl (
  input  wire logic       sys_clk,        // system clock, 25 MHz
  input  wire logic       rst_n,          // async reset, active low
  input  wire logic [7:0] sfr_addr,       // register address
  input  wire logic       sfr_wr,         // write strobe
  input  wire logic [7:0] sfr_wdata,      // write data
  input  wire logic       sfr_rd,         // read strobe
  output logic      [7:0] sfr_rdata,      // read data, one cycle after strobe
  input  wire logic [7:0] ext_req,        // enabled source requests, bit 1 unused
  input  wire logic       match_req,      // port-match pending flag
  input  wire logic       in_low_isr,     // cpu serving low level
  input  wire logic       in_high_isr,    // cpu serving high level
  output logic      [7:0] src_level,      // per-source level, 1 = high
  output logic            match_gated,    // port-match request after mask
  output logic            match_level,    // port-match level, 1 = high
  output logic            high_pend,      // enabled high request pending
  output logic            low_pend,       // enabled low request pending
  output logic            vector_req,     // start service from idle
  output logic            preempt_req     // high request interrupts low service
);

  logic [7:0] prio_one;
  logic [7:0] match_mask;
  logic [7:0] match_prio;

  eipe_sfr_byte #(
    .ADDR  (eipe_pkg::ADDR_PRIO_ONE),
    .WMASK (eipe_pkg::WMASK_PRIO_ONE)
  ) u_prio_one (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .sfr_addr  (sfr_addr),
    .sfr_wr    (sfr_wr),
    .sfr_wdata (sfr_wdata),
    .value     (prio_one)
  );

  // only the enable bit is stored
  eipe_sfr_byte #(
    .ADDR  (eipe_pkg::ADDR_MATCH_MASK),
    .WMASK (eipe_pkg::WMASK_MATCH_MASK)
  ) u_match_mask (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .sfr_addr  (sfr_addr),
    .sfr_wr    (sfr_wr),
    .sfr_wdata (sfr_wdata),
    .value     (match_mask)
  );

  eipe_sfr_byte #(
    .ADDR  (eipe_pkg::ADDR_MATCH_PRIO),
    .WMASK (eipe_pkg::WMASK_MATCH_PRIO)
  ) u_match_prio (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .sfr_addr  (sfr_addr),
    .sfr_wr    (sfr_wr),
    .sfr_wdata (sfr_wdata),
    .value     (match_prio)
  );

  typedef struct packed {
    logic [7:0] rdata;
    logic       high_pend;
    logic       low_pend;
    logic       vector_req;
    logic       preempt_req;
  } eipe_state_t;

  eipe_state_t s_q;
  eipe_state_t s_d;
  logic        m_gated;
  logic        m_level;
  logic [7:0]  src_valid;
  logic        hi_any;
  logic        lo_any;

  // port-match request passes only when enabled
  assign m_gated   = match_req & match_mask[eipe_pkg::BIT_PORT_MATCH];
  // port-match level from its priority bit
  assign m_level   = match_prio[eipe_pkg::BIT_PORT_MATCH];
  assign src_valid = ext_req & eipe_pkg::WMASK_PRIO_ONE;
  assign hi_any    = |(src_valid & prio_one) | (m_gated & m_level);
  assign lo_any    = |(src_valid & ~prio_one) | (m_gated & ~m_level);

  always_comb begin
    s_d = s_q;
    s_d.high_pend = hi_any;
    s_d.low_pend  = lo_any;
    // only a high request preempts low service
    s_d.preempt_req = hi_any & in_low_isr & ~in_high_isr;
    s_d.vector_req  = (hi_any | lo_any) & ~in_low_isr & ~in_high_isr;
    if (sfr_rd) begin
      case (sfr_addr)
        eipe_pkg::ADDR_PRIO_ONE:   s_d.rdata = prio_one;
        eipe_pkg::ADDR_MATCH_MASK: s_d.rdata = match_mask;
        eipe_pkg::ADDR_MATCH_PRIO: s_d.rdata = match_prio;
        default:                   s_d.rdata = eipe_pkg::RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata   = s_q.rdata;
  assign src_level   = prio_one;
  assign match_gated = m_gated;
  assign match_level = m_level;
  assign high_pend   = s_q.high_pend;
  assign low_pend    = s_q.low_pend;
  assign vector_req  = s_q.vector_req;
  assign preempt_req = s_q.preempt_req;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence wr_prio_one;
    sfr_wr && sfr_addr == eipe_pkg::ADDR_PRIO_ONE;
  endsequence

  sequence wr_match_mask;
    sfr_wr && sfr_addr == eipe_pkg::ADDR_MATCH_MASK;
  endsequence

  sequence wr_match_prio;
    sfr_wr && sfr_addr == eipe_pkg::ADDR_MATCH_PRIO;
  endsequence

  sequence rd_match_mask;
    sfr_rd && sfr_addr == eipe_pkg::ADDR_MATCH_MASK;
  endsequence

  chk_timer3_level_store: assert property (
    wr_prio_one ##1 1 |-> src_level[eipe_pkg::BIT_TIMER3] == $past(sfr_wdata[eipe_pkg::BIT_TIMER3]))
    else $error("timer3 level bit not stored");

  chk_comp1_level_store: assert property (
    wr_prio_one |=> src_level[eipe_pkg::BIT_COMP1] == $past(sfr_wdata[eipe_pkg::BIT_COMP1]))
    else $error("comparator1 level bit not stored");

  chk_comp0_high_pend: assert property (
    src_level[eipe_pkg::BIT_COMP0] && ext_req[eipe_pkg::BIT_COMP0] |=> high_pend)
    else $error("comparator0 high request not seen");

  chk_two_wire_low: assert property (
    !src_level[eipe_pkg::BIT_TWO_WIRE] && ext_req[eipe_pkg::BIT_TWO_WIRE] |=> low_pend)
    else $error("two-wire low request not seen");

  chk_mask_upper_zero: assert property (
    rd_match_mask |=> sfr_rdata[7:2] == 6'h00)
    else $error("unused enable bits read nonzero");

  chk_match_gate: assert property (
    match_req |-> match_gated == match_mask[eipe_pkg::BIT_PORT_MATCH])
    else $error("port-match gate wrong");

  chk_mask_bit0_zero: assert property (
    sfr_rd && sfr_addr == eipe_pkg::ADDR_MATCH_MASK |=> !sfr_rdata[0])
    else $error("unused enable bit 0 read nonzero");

  chk_match_level_high: assert property (
    match_gated && match_level |=> high_pend)
    else $error("port-match high level not pending");

  chk_no_same_preempt: assert property (
    in_high_isr |=> !preempt_req && !vector_req)
    else $error("preempted a high level service");

  chk_low_preempt: assert property (
    hi_any && in_low_isr && !in_high_isr |=> preempt_req ##1 (preempt_req || !high_pend || !in_low_isr || in_high_isr))
    else $error("high request failed to preempt");

  chk_timer3_low_pend: assert property (
    !src_level[eipe_pkg::BIT_TIMER3] && ext_req[eipe_pkg::BIT_TIMER3] |=> low_pend)
    else $error("timer3 low request not seen");

  chk_comp1_high_pend: assert property (
    src_level[eipe_pkg::BIT_COMP1] && ext_req[eipe_pkg::BIT_COMP1] |=> high_pend)
    else $error("comparator1 high request not seen");

  chk_comp0_level_store: assert property (
    wr_prio_one |=> src_level[eipe_pkg::BIT_COMP0] == $past(sfr_wdata[eipe_pkg::BIT_COMP0]))
    else $error("comparator0 level bit not stored");

  chk_two_wire_high: assert property (
    src_level[eipe_pkg::BIT_TWO_WIRE] && ext_req[eipe_pkg::BIT_TWO_WIRE] |=> high_pend)
    else $error("two-wire high request not seen");

  chk_two_wire_store: assert property (
    wr_prio_one |=> src_level[eipe_pkg::BIT_TWO_WIRE] == $past(sfr_wdata[eipe_pkg::BIT_TWO_WIRE]))
    else $error("two-wire level bit not stored");

  chk_mask_upper_store: assert property (
    wr_match_mask |=> match_mask[7:2] == 6'h00)
    else $error("unused enable bits stored");

  chk_match_enable_store: assert property (
    wr_match_mask ##1 match_req |-> match_gated == $past(sfr_wdata[eipe_pkg::BIT_PORT_MATCH]))
    else $error("port-match enable not applied");

  chk_mask_bit0_store: assert property (
    wr_match_mask |=> !match_mask[0])
    else $error("unused enable bit 0 stored");

  chk_match_prio_store: assert property (
    wr_match_prio |=> match_level == $past(sfr_wdata[eipe_pkg::BIT_PORT_MATCH]))
    else $error("port-match level bit not stored");

  chk_match_level_low: assert property (
    match_gated && !match_level |=> low_pend)
    else $error("port-match low level not pending");

  chk_vector_from_idle: assert property (
    (hi_any || lo_any) && !in_low_isr && !in_high_isr |=> vector_req)
    else $error("idle cpu not asked to vector");

endmodule
`default_nettype wire

/* inc/eipe_pkg.sv */
package eipe_pkg;

  // special function register addresses
  localparam logic [7:0] ADDR_PRIO_ONE   = 8'hee;
  localparam logic [7:0] ADDR_MATCH_MASK = 8'he7;
  localparam logic [7:0] ADDR_MATCH_PRIO = 8'hcf;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // writable bits of each register, the rest read zero
  localparam logic [7:0] WMASK_PRIO_ONE   = 8'hfd;
  localparam logic [7:0] WMASK_MATCH_MASK = 8'h02;
  localparam logic [7:0] WMASK_MATCH_PRIO = 8'h02;

  // field positions in the extended priority register
  localparam int BIT_TIMER3      = 7;
  localparam int BIT_COMP1       = 6;
  localparam int BIT_COMP0       = 5;
  localparam int BIT_COUNTER_ARR = 4;
  localparam int BIT_CONV_DONE   = 3;
  localparam int BIT_WIN_COMPARE = 2;
  localparam int BIT_TWO_WIRE    = 0;

  // port-match bit in its enable and priority registers
  localparam int BIT_PORT_MATCH = 1;

  localparam int BYTE_W = 8;

endpackage

/* hdl/eipe_sfr_byte.sv */
`timescale 1ns/1ns
`default_nettype none
module eipe_sfr_byte #(
  parameter logic [7:0] ADDR  = 8'h00,
  parameter logic [7:0] WMASK = 8'hff
) (
  input  wire logic       sys_clk,   // system clock
  input  wire logic       rst_n,     // async reset, active low
  input  wire logic [7:0] sfr_addr,  // register address
  input  wire logic       sfr_wr,    // write strobe
  input  wire logic [7:0] sfr_wdata, // write data
  output logic      [7:0] value      // stored value
);

  typedef struct packed {
    logic [7:0] val;
  } eipe_byte_t;

  eipe_byte_t s_q;
  eipe_byte_t s_d;

  // unused bits never store, so they read zero
  always_comb begin
    s_d = s_q;
    if (sfr_wr && sfr_addr == ADDR) begin
      s_d.val = sfr_wdata & WMASK;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.val <= eipe_pkg::RST_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  assign value = s_q.val;

endmodule
`default_nettype wire

/* sim/eipe_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module eipe_cpu_model (
  input  wire logic sys_clk,     // system clock
  input  wire logic rst_n,       // async reset, active low
  input  wire logic vector_req,  // start service from idle
  input  wire logic preempt_req, // high over low request
  input  wire logic high_pend,   // high request pending
  input  wire logic low_pend,    // low request pending
  output logic      in_low_isr,  // serving low level
  output logic      in_high_isr  // serving high level
);
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_low_isr  <= 1'b0;
      in_high_isr <= 1'b0;
    end else begin
      if (vector_req) begin
        in_high_isr <= high_pend;
        in_low_isr  <= !high_pend;
      end
      if (preempt_req)
        in_high_isr <= 1'b1;
      if (!high_pend)
        in_high_isr <= 1'b0;
      if (!high_pend && !low_pend)
        in_low_isr <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* sim/extended_irq_priority_enable_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module extended_irq_priority_enable_bench;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] ext_req = 8'h00;
  logic       sfr_wr = 1'b0;
  logic       sfr_rd = 1'b0;
  logic       match_req = 1'b0;
  logic       rd_q = 1'b0;
  logic       in_low_isr, in_high_isr, match_gated, match_level, high_pend, low_pend, vector_req, preempt_req;
  logic [7:0] sfr_rdata, src_level, d;
  logic [7:0] exp_q[$];
  int         num_errors = 0;
  int         samples_checked = 0;

  always #20 sys_clk = ~sys_clk;

  eipe_ctrl i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .ext_req(ext_req),
    .match_req(match_req), .in_low_isr(in_low_isr), .in_high_isr(in_high_isr),
    .src_level(src_level), .match_gated(match_gated), .match_level(match_level),
    .high_pend(high_pend), .low_pend(low_pend), .vector_req(vector_req), .preempt_req(preempt_req));

  eipe_cpu_model i_cpu (.sys_clk(sys_clk), .rst_n(rst_n), .vector_req(vector_req),
    .preempt_req(preempt_req), .high_pend(high_pend), .low_pend(low_pend),
    .in_low_isr(in_low_isr), .in_high_isr(in_high_isr));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // strobes stay up for back-to-back transfers; the caller drops them
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_rd = 1'b0;
    sfr_wr = 1'b1;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_wr = 1'b0;
    sfr_rd = 1'b1;
    exp_q.push_back(exp);
    cyc(1);
  endtask

  // read data lands one cycle after the read edge
  always @(posedge sys_clk) begin
    if (rd_q)
      chk(sfr_rdata, exp_q.pop_front());
    rd_q <= sfr_rd;
  end

  task automatic conclude;
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #80000;
    num_errors++;
    conclude();
  end

  initial begin
    void'($urandom(45553));
    cyc(2);
    rst_n = 1'b1;
    rd(eipe_pkg::ADDR_PRIO_ONE, eipe_pkg::RST_BYTE); // reset zero
    rd(eipe_pkg::ADDR_MATCH_MASK, eipe_pkg::RST_BYTE); // reset zero
    rd(eipe_pkg::ADDR_MATCH_PRIO, eipe_pkg::RST_BYTE); // reset zero
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom);
      match_req = 1'($urandom);
      ext_req = 8'($urandom);
      wr(eipe_pkg::ADDR_PRIO_ONE, d);
      wr(eipe_pkg::ADDR_MATCH_MASK, d);
      wr(eipe_pkg::ADDR_MATCH_PRIO, d);
      wr(8'h55, ~d);
      rd(eipe_pkg::ADDR_PRIO_ONE, d & eipe_pkg::WMASK_PRIO_ONE);
      rd(eipe_pkg::ADDR_MATCH_MASK, d & 8'h02);
      rd(eipe_pkg::ADDR_MATCH_PRIO, d & 8'h02);
      rd(8'h55, 8'h00);
      chk(src_level, d & 8'hfd);
      chk({7'h00, match_level}, {7'h00, d[1]});
      chk({7'h00, match_gated}, {7'h00, match_req & d[1]});
    end
    // quiet bus and requests, then reset mid-run
    sfr_rd = 1'b0;
    ext_req = 8'h00;
    match_req = 1'b0;
    cyc(2);
    rst_n = 1'b0;
    cyc(1);
    rst_n = 1'b1;
    rd(eipe_pkg::ADDR_PRIO_ONE, eipe_pkg::RST_BYTE); // reset zero
    rd(eipe_pkg::ADDR_MATCH_MASK, eipe_pkg::RST_BYTE); // reset zero
    rd(eipe_pkg::ADDR_MATCH_PRIO, eipe_pkg::RST_BYTE); // reset zero
    wr(eipe_pkg::ADDR_PRIO_ONE, 8'h00);
    sfr_wr = 1'b0;
    ext_req = 8'h20;
    cyc(4);
    chk({low_pend, vector_req, in_low_isr}, 8'h05);
    ext_req = 8'ha0;
    cyc(2);
    chk({high_pend, preempt_req}, 8'h00);
    wr(eipe_pkg::ADDR_PRIO_ONE, 8'h80);
    sfr_wr = 1'b0;
    cyc(1);
    chk({high_pend, preempt_req}, 8'h03);
    cyc(3);
    chk({preempt_req, in_high_isr}, 8'h01);
    cyc(2);
    conclude();
  end
endmodule
`default_nettype wire
